// [hdl/flash_read_pkg.sv]
// Shared constants, types and helpers for the serial flash fast read link
`default_nettype none
package flash_read_pkg;
  // ****************************************
  // Opcodes and field sizes
  // ****************************************
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_QUAD_WORD = 8'he7;
  localparam int ADDR_BITS = 24;
  localparam logic [5:0] ADDR_CLKS_1 = 6'h18;
  localparam logic [5:0] MODE_CLKS_1 = 6'h08;
  localparam logic [5:0] CMD_CLKS = 6'h08;
  localparam logic [5:0] FAST_DUMMY_CLKS = 6'h08;
  localparam logic [5:0] QUAD_IO_DUMMY_CLKS = 6'h04;
  localparam logic [5:0] WORD_DUMMY_CLKS = 6'h02;
  localparam logic [3:0] CONT_MODE_NIBBLE = 4'ha;
  localparam logic [2:0] WRAP_RESET = 3'h4;
  localparam logic [7:0] WRAP_BASE_BYTES = 8'h08;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CLKS = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [5:0] GAP_TICKS = 6'h02;
  typedef enum logic [2:0] {
    DS_IDLE, DS_CMD, DS_ADDR, DS_MODE, DS_DUMMY, DS_DATA, DS_IGNORE
  } dev_state_t;
  typedef enum logic [2:0] {
    HS_IDLE, HS_CMD, HS_ADDR, HS_MODE, HS_DUMMY, HS_DATA, HS_GAP
  } host_state_t;
  // ****************************************
  // Command properties
  // ****************************************
  function automatic logic is_read_op(input logic [7:0] op);
    return op == OP_FAST || op == OP_DUAL_OUT || op == OP_QUAD_OUT ||
           op == OP_DUAL_IO || op == OP_QUAD_IO || op == OP_QUAD_WORD;
  endfunction
  function automatic logic needs_quad(input logic [7:0] op);
    return op == OP_QUAD_OUT || op == OP_QUAD_IO || op == OP_QUAD_WORD;
  endfunction
  function automatic logic has_mode(input logic [7:0] op);
    return op == OP_DUAL_IO || op == OP_QUAD_IO || op == OP_QUAD_WORD;
  endfunction
  function automatic logic [2:0] addr_lanes(input logic [7:0] op);
    if (op == OP_DUAL_IO) begin
      return 3'h2;
    end else if (op == OP_QUAD_IO || op == OP_QUAD_WORD) begin
      return 3'h4;
    end
    return 3'h1;
  endfunction
  function automatic logic [2:0] data_lanes(input logic [7:0] op);
    if (op == OP_FAST) begin
      return 3'h1;
    end else if (op == OP_DUAL_OUT || op == OP_DUAL_IO) begin
      return 3'h2;
    end
    return 3'h4;
  endfunction
  function automatic logic [5:0] dummy_clks(input logic [7:0] op);
    if (op == OP_QUAD_IO) begin
      return QUAD_IO_DUMMY_CLKS;
    end else if (op == OP_QUAD_WORD) begin
      return WORD_DUMMY_CLKS;
    end else if (op == OP_DUAL_IO) begin
      return 6'h00;
    end
    return FAST_DUMMY_CLKS;
  endfunction
  // Clocks for a field: one-lane length divided by the lane count
  function automatic logic [5:0] field_clks(input logic [5:0] c1, input logic [2:0] ln);
    return c1 >> ln[2:1];
  endfunction
  // Top bits of a byte onto the lanes, MSB on the highest lane; one-lane on io1 if so
  function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] ln,
                                           input logic so);
    if (ln == 3'h4) begin
      return b[7:4];
    end else if (ln == 3'h2) begin
      return {2'h0, b[7:6]};
    end
    return so ? {2'h0, b[7], 1'b0} : {3'h0, b[7]};
  endfunction
  function automatic logic [3:0] lane_mask(input logic [2:0] ln);
    return (ln == 3'h4) ? 4'hf : ((ln == 3'h2) ? 4'h3 : 4'h1);
  endfunction
  function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] io,
                                           input logic [2:0] ln);
    if (ln == 3'h4) begin
      return {sh[27:0], io};
    end else if (ln == 3'h2) begin
      return {sh[29:0], io[1:0]};
    end
    return {sh[30:0], io[0]};
  endfunction
endpackage
`default_nettype wire

// [hdl/flash_link_if.sv]
// Link between host controller and flash: select, serial clock, four IO lines
`default_nettype none
interface flash_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] host_io;
  logic [3:0] host_oe;
  logic [3:0] dev_io;
  logic [3:0] dev_oe;
  logic [3:0] io_level;
  // Wire level of each IO line; an undriven line reads high (pull-up)
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_level[i] = dev_oe[i] ? dev_io[i] : (host_oe[i] ? host_io[i] : 1'b1);
    end
  end
  modport host (output cs_n, output sclk, output host_io, output host_oe, input io_level);
  modport dev (input cs_n, input sclk, input io_level, output dev_io, output dev_oe);
endinterface
`default_nettype wire

// [hdl/flash_read_device.sv]
// Flash end of the link: fast read command decoder and data shifter
`default_nettype none
module flash_read_device (
  input wire logic clk,
  input wire logic rst_n,
  flash_link_if.dev link,
  input wire logic quad_io_allow_bit,
  input wire logic wrap_load,
  input wire logic [2:0] wrap_value,
  input wire logic [7:0] mem_data,
  output logic [flash_read_pkg::ADDR_BITS-1:0] mem_addr,
  output logic [2:0] wrap_setting_bits,
  output logic continuous_read_armed,
  output logic read_active
);
  import flash_read_pkg::*;
  // ****************************************
  // Link synchronisers
  // ****************************************
  logic cs_s1;
  logic cs_s2;
  logic ck_s1;
  logic ck_s2;
  logic ck_s3;
  logic [3:0] io_s1;
  logic [3:0] io_s2;
  logic rise;
  logic fall;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else begin
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      ck_s1 <= link.sclk;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      io_s1 <= link.io_level;
      io_s2 <= io_s1;
    end
  end
  assign rise = ck_s2 & ~ck_s3;
  assign fall = ~ck_s2 & ck_s3;
  // ****************************************
  // Decoder state
  // ****************************************
  dev_state_t state_reg;
  dev_state_t state_next;
  logic [7:0] op_reg;
  logic [7:0] op_next;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [31:0] sh_reg;
  logic [31:0] sh_next;
  logic [ADDR_BITS-1:0] addr_reg;
  logic [ADDR_BITS-1:0] addr_next;
  logic [7:0] obuf_reg;
  logic [7:0] obuf_next;
  logic [2:0] bcnt_reg;
  logic [2:0] bcnt_next;
  logic [3:0] io_reg;
  logic [3:0] io_next;
  logic [3:0] oe_reg;
  logic [3:0] oe_next;
  logic cont_reg;
  logic cont_next;
  logic [2:0] wrap_reg;
  logic [2:0] wrap_next;
  logic active_reg;
  logic active_next;
  // Next address: plain increment, or wrap inside the aligned section
  function automatic logic [ADDR_BITS-1:0] next_addr(input logic [ADDR_BITS-1:0] a,
                                                      input logic [7:0] op,
                                                      input logic [2:0] w);
    logic [7:0] m;
    logic [7:0] lo;
    m = (WRAP_BASE_BYTES << w[2:1]) - 8'h01;
    lo = a[7:0] + 8'h01;
    if (!w[0] && (op == OP_QUAD_IO || op == OP_QUAD_WORD)) begin
      return {a[ADDR_BITS-1:8], (a[7:0] & ~m) | (lo & m)};
    end
    return a + ADDR_BITS'(1);
  endfunction
  always_comb begin
    logic [31:0] sh_in;
    logic [7:0] byte_out;
    logic [2:0] ln;
    sh_in = 32'h0000_0000;
    byte_out = 8'h00;
    ln = 3'h1;
    state_next = state_reg;
    op_next = op_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    addr_next = addr_reg;
    obuf_next = obuf_reg;
    bcnt_next = bcnt_reg;
    io_next = io_reg;
    oe_next = oe_reg;
    cont_next = cont_reg;
    wrap_next = wrap_reg;
    active_next = 1'b0;
    if (wrap_load) begin
      wrap_next = wrap_value;
    end
    if (cs_s2) begin
      state_next = DS_IDLE;
      oe_next = 4'h0;
      cnt_next = 6'h00;
    end else begin
      case (state_reg)
        DS_IDLE: begin
          sh_next = 32'h0000_0000;
          cnt_next = 6'h00;
          state_next = cont_reg ? DS_ADDR : DS_CMD;
        end
        DS_CMD: begin
          if (rise) begin
            sh_in = shift_in(sh_reg, io_s2, 3'h1);
            sh_next = sh_in;
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == CMD_CLKS - 6'h01) begin
              cnt_next = 6'h00;
              op_next = sh_in[7:0];
              if (!is_read_op(sh_in[7:0])) begin
                state_next = DS_IGNORE;
              end else if (needs_quad(sh_in[7:0]) && !quad_io_allow_bit) begin
                state_next = DS_IGNORE;
              end else begin
                state_next = DS_ADDR;
              end
            end
          end
        end
        DS_ADDR: begin
          ln = addr_lanes(op_reg);
          if (rise) begin
            sh_in = shift_in(sh_reg, io_s2, ln);
            sh_next = sh_in;
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == field_clks(ADDR_CLKS_1, ln) - 6'h01) begin
              cnt_next = 6'h00;
              addr_next = sh_in[ADDR_BITS-1:0];
              state_next = has_mode(op_reg) ? DS_MODE : DS_DUMMY;
            end
          end
        end
        DS_MODE: begin
          ln = addr_lanes(op_reg);
          if (rise) begin
            sh_in = shift_in(sh_reg, io_s2, ln);
            sh_next = sh_in;
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == field_clks(MODE_CLKS_1, ln) - 6'h01) begin
              cnt_next = 6'h00;
              cont_next = sh_in[7:4] == CONT_MODE_NIBBLE;
              bcnt_next = 3'h0;
              state_next = (dummy_clks(op_reg) == 6'h00) ? DS_DATA : DS_DUMMY;
            end
          end
        end
        DS_DUMMY: begin
          if (rise) begin
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == dummy_clks(op_reg) - 6'h01) begin
              cnt_next = 6'h00;
              bcnt_next = 3'h0;
              state_next = DS_DATA;
            end
          end
        end
        DS_DATA: begin
          ln = data_lanes(op_reg);
          active_next = 1'b1;
          if (fall) begin
            byte_out = (bcnt_reg == 3'h0) ? mem_data : obuf_reg;
            io_next = lane_bits(byte_out, ln, 1'b1);
            oe_next = (ln == 3'h1) ? 4'h2 : lane_mask(ln);
            obuf_next = byte_out << ln;
            bcnt_next = bcnt_reg + 3'h1;
            if (bcnt_reg == 3'h0) begin
              addr_next = next_addr(addr_reg, op_reg, wrap_reg);
            end
            if (bcnt_reg == 3'(3'h7 >> ln[2:1])) begin
              bcnt_next = 3'h0;
            end
          end
        end
        default: begin
          oe_next = 4'h0;
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DS_IDLE;
      op_reg <= 8'h00;
      cnt_reg <= 6'h00;
      sh_reg <= 32'h0000_0000;
      addr_reg <= '0;
      obuf_reg <= 8'h00;
      bcnt_reg <= 3'h0;
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
      cont_reg <= 1'b0;
      wrap_reg <= WRAP_RESET;
      active_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      addr_reg <= addr_next;
      obuf_reg <= obuf_next;
      bcnt_reg <= bcnt_next;
      io_reg <= io_next;
      oe_reg <= oe_next;
      cont_reg <= cont_next;
      wrap_reg <= wrap_next;
      active_reg <= active_next;
    end
  end
  assign link.dev_io = io_reg;
  assign link.dev_oe = oe_reg;
  assign mem_addr = addr_reg;
  assign wrap_setting_bits = wrap_reg;
  assign continuous_read_armed = cont_reg;
  assign read_active = active_reg;
endmodule
`default_nettype wire

// [hdl/flash_read_host.sv]
// Host end of the link: issues one fast read and collects the data bytes
`default_nettype none
module flash_read_host #(
  parameter int HALF_CLKS = flash_read_pkg::SCLK_HALF_CLKS
) (
  input wire logic clk,
  input wire logic rst_n,
  flash_link_if.host link,
  input wire logic start,
  input wire logic [7:0] cmd_code,
  input wire logic skip_opcode,
  input wire logic [flash_read_pkg::ADDR_BITS-1:0] start_addr,
  input wire logic [7:0] mode_byte,
  input wire logic [15:0] byte_count,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  import flash_read_pkg::*;
  // ****************************************
  // Input synchroniser and clock divider
  // ****************************************
  logic [3:0] io_s1;
  logic [3:0] io_s2;
  logic [7:0] div_reg;
  logic tick;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
      div_reg <= 8'h00;
    end else begin
      io_s1 <= link.io_level;
      io_s2 <= io_s1;
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
    end
  end
  assign tick = div_reg == 8'(HALF_CLKS - 1);
  // ****************************************
  // Transfer sequencer
  // ****************************************
  host_state_t st_reg;
  host_state_t st_next;
  logic [7:0] op_reg;
  logic [7:0] op_next;
  logic [39:0] tx_reg;
  logic [39:0] tx_next;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [15:0] left_reg;
  logic [15:0] left_next;
  logic [7:0] rx_reg;
  logic [7:0] rx_next;
  logic [3:0] rb_reg;
  logic [3:0] rb_next;
  logic cs_n_reg;
  logic cs_n_next;
  logic sclk_reg;
  logic sclk_next;
  logic [3:0] io_reg;
  logic [3:0] io_next;
  logic [3:0] oe_reg;
  logic [3:0] oe_next;
  logic [7:0] rd_reg;
  logic [7:0] rd_next;
  logic valid_reg;
  logic valid_next;
  logic busy_reg;
  logic busy_next;
  always_comb begin
    logic [2:0] ln;
    logic [5:0] len;
    logic [7:0] rx_in;
    host_state_t nx;
    ln = (st_reg == HS_CMD) ? 3'h1 : addr_lanes(op_reg);
    len = CMD_CLKS;
    rx_in = 8'h00;
    nx = st_reg;
    st_next = st_reg;
    op_next = op_reg;
    tx_next = tx_reg;
    cnt_next = cnt_reg;
    left_next = left_reg;
    rx_next = rx_reg;
    rb_next = rb_reg;
    cs_n_next = cs_n_reg;
    sclk_next = sclk_reg;
    io_next = io_reg;
    oe_next = oe_reg;
    rd_next = rd_reg;
    valid_next = 1'b0;
    if (st_reg == HS_ADDR) begin
      len = field_clks(ADDR_CLKS_1, ln);
    end else if (st_reg == HS_MODE) begin
      len = field_clks(MODE_CLKS_1, ln);
    end else if (st_reg == HS_DUMMY) begin
      len = dummy_clks(op_reg);
    end
    if (st_reg == HS_IDLE) begin
      if (start) begin
        op_next = cmd_code;
        left_next = byte_count;
        cnt_next = 6'h00;
        rb_next = 4'h0;
        cs_n_next = 1'b0;
        ln = skip_opcode ? addr_lanes(cmd_code) : 3'h1;
        tx_next = skip_opcode ? {start_addr, mode_byte, 8'h00}
                              : {cmd_code, start_addr, mode_byte};
        st_next = skip_opcode ? HS_ADDR : HS_CMD;
        io_next = lane_bits(tx_next[39:32], ln, 1'b0);
        oe_next = lane_mask(ln);
      end
    end else if (st_reg == HS_GAP) begin
      if (tick) begin
        cnt_next = cnt_reg + 6'h01;
        if (cnt_reg == GAP_TICKS - 6'h01) begin
          st_next = HS_IDLE;
        end
      end
    end else if (tick && !sclk_reg) begin
      sclk_next = 1'b1;
    end else if (tick) begin
      sclk_next = 1'b0;
      if (st_reg == HS_DATA) begin
        ln = data_lanes(op_reg);
        rx_in = 8'(shift_in({24'h00_0000, rx_reg},
                            (ln == 3'h1) ? {3'h0, io_s2[1]} : io_s2, ln));
        rx_next = rx_in;
        rb_next = rb_reg + {1'b0, ln};
        if (rb_reg + {1'b0, ln} == 4'h8) begin
          rb_next = 4'h0;
          rd_next = rx_in;
          valid_next = 1'b1;
          left_next = left_reg - 16'h0001;
          if (left_reg <= 16'h0001) begin
            cs_n_next = 1'b1;
            cnt_next = 6'h00;
            st_next = HS_GAP;
          end
        end
      end else begin
        tx_next = tx_reg << ln;
        cnt_next = cnt_reg + 6'h01;
        if (cnt_reg == len - 6'h01) begin
          cnt_next = 6'h00;
          case (st_reg)
            HS_CMD: nx = HS_ADDR;
            HS_ADDR: nx = has_mode(op_reg) ? HS_MODE : HS_DUMMY;
            HS_MODE: nx = (dummy_clks(op_reg) == 6'h00) ? HS_DATA : HS_DUMMY;
            default: nx = HS_DATA;
          endcase
          st_next = nx;
          ln = addr_lanes(op_reg);
        end
        io_next = lane_bits(tx_next[39:32], ln, 1'b0);
        oe_next = (nx == HS_DUMMY || nx == HS_DATA) ? 4'h0 : lane_mask(ln);
      end
    end
    busy_next = st_next != HS_IDLE;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= HS_IDLE;
      op_reg <= 8'h00;
      tx_reg <= 40'h00_0000_0000;
      cnt_reg <= 6'h00;
      left_reg <= 16'h0000;
      rx_reg <= 8'h00;
      rb_reg <= 4'h0;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
      rd_reg <= 8'h00;
      valid_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      op_reg <= op_next;
      tx_reg <= tx_next;
      cnt_reg <= cnt_next;
      left_reg <= left_next;
      rx_reg <= rx_next;
      rb_reg <= rb_next;
      cs_n_reg <= cs_n_next;
      sclk_reg <= sclk_next;
      io_reg <= io_next;
      oe_reg <= oe_next;
      rd_reg <= rd_next;
      valid_reg <= valid_next;
      busy_reg <= busy_next;
    end
  end
  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.host_io = io_reg;
  assign link.host_oe = oe_reg;
  assign busy = busy_reg;
  assign rd_data = rd_reg;
  assign rd_valid = valid_reg;
endmodule
`default_nettype wire

// [verification/flash_read_props.sv]
// Concurrent checks on the flash link wire between host and flash ends
`default_nettype none
module flash_read_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] host_io,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_io,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] io_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Link properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  idle_clock_a: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("link clock moves while deselected");
  one_driver_a: assert property (!(|(host_oe & dev_oe)))
    else $error("both ends drive an IO line");
  host_hold_a: assert property (sclk && $past(sclk) |-> $stable(host_io) && $stable(host_oe))
    else $error("host IO changes while link clock high");
  dev_hold_a: assert property (sclk && $past(sclk) |-> $stable(dev_io) && $stable(dev_oe))
    else $error("flash IO changes while link clock high");
  high_half_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high half is not four cycles");
  low_half_a: assert property ($fell(sclk) && !cs_n |-> !sclk [*4])
    else $error("link clock low half too short");
  flash_release_a: assert property ($rose(cs_n) |-> ##[0:5] (dev_oe == 4'h0))
    else $error("flash keeps driving after deselect");
  host_release_a: assert property (cs_n |-> host_oe == 4'h0)
    else $error("host drives IO while deselected");
  lane_set_a: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("flash drives an illegal lane set");
  serial_out_level_a: assert property (dev_oe[1] |-> io_level[1] == dev_io[1])
    else $error("flash serial output not seen on the line");
  select_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select high time too short");
  cover property ($fell(cs_n));
  cover property (dev_oe == 4'hf);
  cover property (dev_oe == 4'h3);
  cover property (dev_oe == 4'h2 && !cs_n);
endmodule
`default_nettype wire

// [verification/serial_flash_fast_read_engine_bench.sv]
// Self-checking bench joining the host and flash ends of the fast read link
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, g, e); end end
module serial_flash_fast_read_engine_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_read_pkg::*;
  logic clk, rst_n, start, skip_opcode, quad_io_allow_bit, wrap_load, sclk_d;
  logic [7:0] cmd_code, mode_byte, mem_data, rd_data;
  logic [23:0] start_addr, mem_addr;
  logic [15:0] byte_count;
  logic [2:0] wrap_value, wrap_setting_bits;
  logic continuous_read_armed, read_active, busy, rd_valid;
  int fail_count, checked, rises;
  flash_link_if link();
  flash_read_host i_flash_read_host (.clk(clk), .rst_n(rst_n), .link(link), .start(start),
    .cmd_code(cmd_code), .skip_opcode(skip_opcode), .start_addr(start_addr),
    .mode_byte(mode_byte), .byte_count(byte_count), .busy(busy), .rd_data(rd_data),
    .rd_valid(rd_valid));
  flash_read_device i_flash_read_device (.clk(clk), .rst_n(rst_n), .link(link),
    .quad_io_allow_bit(quad_io_allow_bit), .wrap_load(wrap_load), .wrap_value(wrap_value),
    .mem_data(mem_data), .mem_addr(mem_addr), .wrap_setting_bits(wrap_setting_bits),
    .continuous_read_armed(continuous_read_armed), .read_active(read_active));
  flash_read_props i_flash_read_props (.clk(clk), .rst_n(rst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .host_io(link.host_io), .host_oe(link.host_oe), .dev_io(link.dev_io),
    .dev_oe(link.dev_oe), .io_level(link.io_level));
  // ****************************************
  // Memory image and link clock counting
  // ****************************************
  function automatic logic [7:0] mem_of(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [23:0] exp_a(input logic [23:0] a, input int k, input int wl);
    logic [7:0] m;
    m = 8'(wl - 1);
    if (wl == 0) return a + 24'(k);
    return {a[23:8], (a[7:0] & ~m) | ((a[7:0] + 8'(k)) & m)};
  endfunction
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    mem_data <= mem_of(mem_addr);
    sclk_d <= link.sclk;
    if (start) rises <= 0;
    else if (!link.cs_n && link.sclk && !sclk_d) rises <= rises + 1;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    $display("counts: checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wrap(input logic [2:0] v);
    @(posedge clk);
    wrap_value <= v;
    wrap_load <= 1'b1;
    @(posedge clk);
    wrap_load <= 1'b0;
    @(negedge clk);
    `CHK(wrap_setting_bits, v)
  endtask
  task automatic rd(input logic [7:0] op, input logic sk, input logic [23:0] a,
                    input logic [7:0] md, input int n, input int wl, input logic bad);
    int k, t, pre, ld, clks;
    // Link clocks after the opcode, per op: address, mode and dummy phases
    case (op)
      OP_DUAL_IO: begin pre = 16; ld = 2; end
      OP_QUAD_IO: begin pre = 12; ld = 4; end
      OP_QUAD_WORD: begin pre = 10; ld = 4; end
      default: begin pre = 32; ld = (op == OP_FAST) ? 1 : ((op == OP_DUAL_OUT) ? 2 : 4); end
    endcase
    clks = (sk ? 0 : 8) + pre + n * 8 / ld;
    @(posedge clk);
    cmd_code <= op;
    skip_opcode <= sk;
    start_addr <= a;
    mode_byte <= md;
    byte_count <= 16'(n);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    for (t = 0; t < 5000; t++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) begin
        `CHK(rd_data, bad ? 8'hff : mem_of(exp_a(a, k, wl)))
        `CHK(read_active, !bad)
        k++;
      end
      if (busy === 1'b0) break;
    end
    if (t == 5000) begin
      fail_count++;
      finish_test();
    end
    `CHK(k, n)
    if (!bad) `CHK(mem_addr, exp_a(a, n, wl))
    `CHK(rises, clks)
    `CHK(read_active, 1'b0)
    `CHK(link.io_level, 4'hf)
    $display("read %h done", op);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    skip_opcode = 1'b0;
    cmd_code = 8'h00;
    mode_byte = 8'h00;
    start_addr = 24'h00_0000;
    byte_count = 16'h0000;
    quad_io_allow_bit = 1'b0;
    wrap_load = 1'b0;
    wrap_value = 3'h0;
    fail_count = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(wrap_setting_bits, 3'h4)
    `CHK(continuous_read_armed, 1'b0)
    rd(OP_FAST, 0, 24'h00_12fe, 8'h00, 3, 0, 0);
    rd(OP_DUAL_OUT, 0, 24'h00_0341, 8'h00, 2, 0, 0);
    rd(OP_QUAD_OUT, 0, 24'h00_0010, 8'h00, 2, 0, 1);
    @(posedge clk);
    quad_io_allow_bit <= 1'b1;
    rd(OP_QUAD_OUT, 0, 24'h00_0010, 8'h00, 2, 0, 0);
    rd(OP_DUAL_IO, 0, 24'h00_0455, 8'ha5, 2, 0, 0);
    `CHK(continuous_read_armed, 1'b1)
    rd(OP_DUAL_IO, 1, 24'h00_0460, 8'h00, 2, 0, 0);
    `CHK(continuous_read_armed, 1'b0)
    rd(OP_QUAD_IO, 0, 24'h00_0503, 8'ha0, 2, 0, 0);
    rd(OP_QUAD_IO, 1, 24'h00_0517, 8'h11, 1, 0, 0);
    `CHK(continuous_read_armed, 1'b0)
    for (int i = 0; i < 4; i++) begin
      wrap({i[1:0], 1'b0});
      rd(OP_QUAD_IO, 0, {16'h0006, 8'(24 * (1 << i) - 2)}, 8'h00, 4, 8 << i, 0);
    end
    rd(OP_QUAD_WORD, 0, 24'h00_07fc, 8'h00, 6, 64, 0);
    wrap(3'h1);
    rd(OP_QUAD_IO, 0, 24'h00_06fe, 8'h00, 3, 0, 0);
    finish_test();
  end
endmodule
`default_nettype wire
